// File: design/sigp_signal_coprocessor.sv
`timescale 1ns/1ns
// Summary of operation
// (RULE1) Program store holds 256 words of 17 bits, one word per instruction.
// (RULE2) Program words 250 to 255 are kept for test and never loaded.
// (RULE3) Data memory is 32 bases of 8 words; only the base addresses the core.
// (RULE4) Displacements 0-3 are writable, 4-7 are constants.
// (RULE5) All eight words of a base read at once; U and V picked independently, but direct mode gives both the same word.
// (RULE6) An 8-word scratchpad may replace the memory word on the V port.
// (RULE7) Memory read happens before write-back in every instruction.
// (RULE8) V data enters the first delay stage, then moves on next instruction.
// (RULE9) Delayed write-back stores the second delay stage into memory.
// (RULE10) One return register gives one level of subroutine nesting.
// (RULE11) Loop counter holds up to 32; jumps test it for zero directly.
// (RULE12) Loop counter loads from the input register or the accumulator.
// (RULE13) Index register is 5 bits and increments by one on command.
// (RULE14) Table ops use the index as base; word is data or jump target.
// (RULE15) Dual tracking uses base and index together; index steps block moves.
// (RULE16) 16-bit two's complement add/subtract with zero, negative, overflow.
// (RULE17) Accumulator captures the sum; shifter halves it keeping sign.
// (RULE18) Multiplier truncates inputs to 12 bits, rounds, keeps 16 MSBs.
// (RULE19) Operands are signed fractions; only minus one squared overflows, and it saturates to 7FFF.
// (RULE20) Product of operands loaded in one instruction is ready the next.
// (RULE21) Only five product ops consume the product; multiplier runs always.
// (RULE22) Multiplier latches load on memory modes, hold on literal or jump.
// (RULE23) Control-mode address is not decoded but still sets up multiplier.
// (RULE24) Loop counter stops at zero when decremented.
// (RULE25) Call saves next address and jumps; return reloads that address.
// (RULE26) Clearing run resets PC, counters, base, index and accumulator.
module sigp_signal_coprocessor
   import sigp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic prog_we,
   input wire logic [sigp_pkg::IADDR_W-1:0] prog_addr,
   input wire logic [sigp_pkg::INSTR_W-1:0] prog_data,
   input wire logic const_we,
   input wire logic [7:0] const_addr,
   input wire logic [sigp_pkg::DATA_W-1:0] const_data,
   input wire logic in_we,
   input wire logic [sigp_pkg::DATA_W-1:0] in_data,
   output logic [sigp_pkg::DATA_W-1:0] out_data,
   output logic out_valid
);
   import sigp_pkg::*;

   if (INSTR_CYC < 4 || INSTR_CYC > 16) begin : g_chk
      $error("sigp: instruction cycle must span 4 to 16 clocks");
   end

   typedef struct packed {
      logic [7:0] pc;
      logic [3:0] ph;
      logic [7:0] ret;
      logic [LC_W-1:0] lc;
      logic [BASE_W-1:0] ix;
      logic [BASE_W-1:0] bas;
      logic [DATA_W-1:0] acc;
      logic zf;
      logic nf;
      logic vf;
      logic [DATA_W-1:0] vm;
      logic [DATA_W-1:0] vs;
      logic [DATA_W-1:0] ma;
      logic [DATA_W-1:0] mb;
      logic [DATA_W-1:0] prod;
      logic [DATA_W-1:0] inr;
      logic [DATA_W-1:0] outw;
      logic outv;
      logic [DISPS-1:0][DATA_W-1:0] scr;
   } sigp_state_t;

   sigp_state_t s_r;
   sigp_state_t s_nxt;

   // ----------------------------------------
   // Memories
   // ----------------------------------------
   logic [INSTR_W-1:0] ins;
   logic [DISPS*DATA_W-1:0] urow;
   logic [DISPS*DATA_W-1:0] vrow;
   logic [BASE_W-1:0] ub;
   logic [BASE_W-1:0] vb;
   logic [DISP_W-1:0] ud;
   logic [DISP_W-1:0] vd;
   logic p_we;
   logic [DATA_W-1:0] wdat;

   sigp_imem #(
      .WORDS(IWORDS),
      .AW(IADDR_W),
      .DW(INSTR_W)
   ) u_imem (
      .sys_clk(sys_clk),
      .rst(rst),
      .wr_en(prog_we && prog_addr < TEST_FIRST), // (RULE2)
      .wr_addr(prog_addr),
      .wr_data(prog_data),
      .rd_addr(s_r.pc), // (RULE1)
      .rd_data(ins)
   );

   sigp_dmem #(
      .BASES(BASES),
      .BW(BASE_W),
      .DISPS(DISPS),
      .DW_D(DISP_W),
      .RAMS(RAM_DISPS),
      .DW(DATA_W)
   ) u_dmem (
      .sys_clk(sys_clk),
      .rst(rst),
      .u_base(ub),
      .v_base(vb),
      .u_row(urow),
      .v_row(vrow),
      .wr_en(const_we || p_we),
      .wr_force(const_we),
      .wr_base(const_we ? const_addr[7:3] : vb),
      .wr_disp(const_we ? const_addr[2:0] : vd),
      .wr_data(const_we ? const_data : wdat)
   );

   // ----------------------------------------
   // Decode and operand select
   // ----------------------------------------
   sigp_op2_t op2;
   sigp_op1_t op1;
   logic [7:0] opd;
   logic tbl;
   logic vix;
   logic dir;
   logic hold;
   logic scr_v;
   logic wr;
   logic [DATA_W-1:0] uw;
   logic [DATA_W-1:0] vw;
   logic [LC_W-1:0] lcdec;

   assign op2 = sigp_op2_t'(ins[OP2_HI:OP2_LO]);
   assign op1 = sigp_op1_t'(ins[OP1_HI:OP1_LO]);
   assign opd = ins[7:0];
   assign tbl = (op2 == O2_TDAT) || (op2 == O2_TJMP); // (RULE14)
   assign vix = tbl || (op2 == O2_DUAL) || (op2 == O2_BLK) || (op2 == O2_JDUAL); // (RULE15)
   assign dir = ~opd[MODE_BIT] & ~vix;
   // Jump targets and literals are not addresses, so the set-up is kept
   assign hold = (op2 inside {O2_JLC, O2_JZ, O2_JN, O2_JO, O2_CALL, O2_JDUAL})
      || (op2 == O2_LDBAS) || (op2 == O2_TJMP); // (RULE22)
   assign ub = dir ? opd[6:2] : (tbl ? s_r.ix : s_r.bas);
   assign vb = dir ? opd[6:2] : (vix ? s_r.ix : s_r.bas);
   assign ud = dir ? {opd[1:0], 1'b0} : opd[5:3];
   assign vd = dir ? {opd[1:0], 1'b0} : opd[2:0];
   assign scr_v = ~dir & ~vix & opd[SCR_BIT]; // (RULE6)
   assign uw = urow[ud*DATA_W +: DATA_W]; // (RULE5)
   assign vw = scr_v ? s_r.scr[vd] : vrow[vd*DATA_W +: DATA_W]; // (RULE6)
   assign wr = op2 inside {O2_DELAYED_WRITEBACK_OP, O2_DELAYED_WRITEBACK_BUMP_BASE_OP, O2_TACV, O2_BLK};
   assign wdat = (op2 == O2_TACV || op2 == O2_BLK) ? s_r.acc : s_r.vs; // (RULE9)
   // Writes land after the read of the same instruction
   assign p_we = run && s_r.ph == PH_WRITE && wr && !scr_v && !const_we; // (RULE7)
   assign lcdec = (s_r.lc == '0) ? '0 : s_r.lc - 1'b1; // (RULE24)

   // ----------------------------------------
   // Adder/subtractor and multiplier
   // ----------------------------------------
   function automatic logic [16:0] sigp_asu(
      input logic [15:0] a,
      input logic [15:0] b,
      input logic sub
   );
      logic [15:0] bb;
      logic [15:0] sm;
      bb = sub ? ~b : b;
      sm = a + bb + {15'h0000, sub};
      return {(a[15] == bb[15]) && (sm[15] != a[15]), sm}; // (RULE16)
   endfunction

   logic signed [23:0] mprod;
   logic [23:0] mrnd;
   logic [DATA_W-1:0] pnext;
   logic mneg1;

   // Inputs cut to their top 12 bits; the product is re-rounded to 16
   assign mprod = $signed(s_r.ma[DATA_W-1 -: MUL_IN_W]) * $signed(s_r.mb[DATA_W-1 -: MUL_IN_W]); // (RULE18)
   assign mrnd = mprod + MUL_RND; // (RULE18)
   // Minus one squared is the only fraction product out of range
   assign mneg1 = s_r.ma[DATA_W-1 -: MUL_IN_W] == 12'h800 && s_r.mb[DATA_W-1 -: MUL_IN_W] == 12'h800;
   assign pnext = mneg1 ? MUL_SAT : mrnd[22:7]; // (RULE19)

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [16:0] ar;
      logic ald;
      ar = '0;
      ald = 1'b0;
      s_nxt = s_r;
      s_nxt.prod = pnext; // (RULE20) (RULE21)
      s_nxt.outv = 1'b0;
      if (in_we) begin
         s_nxt.inr = in_data;
      end
      if (!run) begin
         s_nxt.ph = PH_FETCH;
         s_nxt.pc = PC_RST; // (RULE26)
         s_nxt.lc = '0;
         s_nxt.ix = '0;
         s_nxt.bas = '0;
         s_nxt.acc = ACC_RST;
      end else begin
         s_nxt.ph = (s_r.ph == PH_LAST) ? PH_FETCH : s_r.ph + 4'h1;
         if (s_r.ph == PH_EXEC) begin
            if (!hold) begin
               s_nxt.ma = uw; // (RULE22) (RULE23)
               s_nxt.mb = vw;
               s_nxt.vs = s_r.vm; // (RULE8)
               s_nxt.vm = vw; // (RULE8)
            end
            if (op2 == O2_MODE) begin
               ald = (op1 == O1_CLR); // (RULE23)
            end else begin
               ald = 1'b1;
               case (op1)
                  O1_LDP: ar = {1'b0, s_r.prod}; // (RULE21)
                  O1_APA: ar = sigp_asu(s_r.acc, s_r.prod, 1'b0); // (RULE21)
                  O1_APU: ar = sigp_asu(uw, s_r.prod, 1'b0); // (RULE21)
                  O1_SPA: ar = sigp_asu(s_r.acc, s_r.prod, 1'b1); // (RULE21)
                  O1_SPU: ar = sigp_asu(uw, s_r.prod, 1'b1); // (RULE21)
                  O1_AUV: ar = sigp_asu(uw, vw, 1'b0); // (RULE16)
                  O1_LDV: ar = {1'b0, vw};
                  O1_LDU: ar = {1'b0, uw};
                  O1_SHR: ar = {1'b0, s_r.acc[15], s_r.acc[15:1]}; // (RULE17)
                  O1_CLR: ar = '0;
                  O1_OUT: begin
                     ald = 1'b0;
                     s_nxt.outw = s_r.acc;
                     s_nxt.outv = 1'b1;
                  end
                  default: ald = 1'b0;
               endcase
               if (op2 == O2_TDAT && op1 == O1_NOP) begin
                  ald = 1'b1;
                  ar = {1'b0, vw}; // (RULE14)
               end
            end
            if (ald) begin
               s_nxt.acc = ar[15:0]; // (RULE17)
               s_nxt.zf = ar[15:0] == '0; // (RULE16)
               s_nxt.nf = ar[15];
               s_nxt.vf = ar[16];
            end
         end
         if (s_r.ph == PH_WRITE) begin
            if (wr && scr_v) begin
               s_nxt.scr[vd] = wdat; // (RULE9)
            end
            s_nxt.pc = s_r.pc + 8'h01;
            case (op2)
               O2_DELAYED_WRITEBACK_BUMP_BASE_OP: s_nxt.bas = s_r.bas + 1'b1;
               O2_JLC: begin
                  if (s_r.lc != '0) s_nxt.pc = opd; // (RULE11)
                  s_nxt.lc = lcdec;
               end
               O2_JDUAL: begin
                  if (s_r.lc != '0) s_nxt.pc = opd; // (RULE11)
                  s_nxt.lc = lcdec;
                  s_nxt.bas = s_r.bas + 1'b1; // (RULE15)
                  s_nxt.ix = s_r.ix + 1'b1;
               end
               O2_JZ: if (s_r.zf) s_nxt.pc = opd;
               O2_JN: if (s_r.nf) s_nxt.pc = opd;
               O2_JO: if (s_r.vf) s_nxt.pc = opd;
               O2_CALL: begin
                  s_nxt.ret = s_r.pc + 8'h01; // (RULE10) (RULE25)
                  s_nxt.pc = opd;
               end
               O2_RET: s_nxt.pc = s_r.ret; // (RULE25)
               O2_TJMP: s_nxt.pc = vw[7:0]; // (RULE14)
               O2_LCIN: s_nxt.lc = (s_r.inr[5:0] > LC_MAX) ? LC_MAX : s_r.inr[5:0]; // (RULE12)
               O2_LCACC: s_nxt.lc = {1'b0, s_r.acc[15:11]}; // (RULE12)
               O2_INCIX: s_nxt.ix = s_r.ix + 1'b1; // (RULE13)
               O2_BLK: s_nxt.ix = s_r.ix + 1'b1; // (RULE15)
               O2_LDBAS: s_nxt.bas = opd[4:0];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign out_data = s_r.outw;
   assign out_valid = s_r.outv;
endmodule

// File: design/sigp_pkg.sv
package sigp_pkg;

   // ----------------------------------------
   // Widths and sizes
   // ----------------------------------------
   localparam int DATA_W = 16;
   localparam int IADDR_W = 8;
   localparam int INSTR_W = 17;
   localparam int IWORDS = 256;
   localparam logic [7:0] TEST_FIRST = 8'hFA;
   localparam int BASE_W = 5;
   localparam int BASES = 32;
   localparam int DISP_W = 3;
   localparam int DISPS = 8;
   localparam int RAM_DISPS = 4;
   localparam int LC_W = 6;
   localparam logic [5:0] LC_MAX = 6'h20;
   localparam int MUL_IN_W = 12;
   localparam logic [23:0] MUL_RND = 24'h000040;
   localparam logic [15:0] MUL_SAT = 16'h7FFF;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 20;
   localparam int INSTR_NS = 300;
   localparam int INSTR_CYC = INSTR_NS / CLK_NS;
   localparam logic [3:0] PH_FETCH = 4'h0;
   localparam logic [3:0] PH_EXEC = 4'h2;
   localparam logic [3:0] PH_WRITE = 4'h3;
   localparam logic [3:0] PH_LAST = 4'(INSTR_CYC - 1);

   // ----------------------------------------
   // Instruction fields and reset values
   // ----------------------------------------
   localparam int OP2_HI = 16;
   localparam int OP2_LO = 12;
   localparam int OP1_HI = 11;
   localparam int OP1_LO = 8;
   localparam int MODE_BIT = 7;
   localparam int SCR_BIT = 6;
   localparam logic [7:0] PC_RST = 8'h00;
   localparam logic [15:0] ACC_RST = 16'h0000;

   typedef enum logic [3:0] {
      O1_NOP = 4'h0,
      O1_LDP = 4'h1,
      O1_APA = 4'h2,
      O1_APU = 4'h3,
      O1_SPA = 4'h4,
      O1_SPU = 4'h5,
      O1_AUV = 4'h6,
      O1_LDV = 4'h7,
      O1_LDU = 4'h8,
      O1_SHR = 4'h9,
      O1_OUT = 4'hA,
      O1_CLR = 4'hB
   } sigp_op1_t;

   typedef enum logic [4:0] {
      O2_NOP = 5'h00,
      O2_DELAYED_WRITEBACK_OP = 5'h01,
      O2_DELAYED_WRITEBACK_BUMP_BASE_OP = 5'h02,
      O2_TACV = 5'h03,
      O2_JLC = 5'h04,
      O2_JZ = 5'h05,
      O2_JN = 5'h06,
      O2_JO = 5'h07,
      O2_CALL = 5'h08,
      O2_RET = 5'h09,
      O2_LCIN = 5'h0A,
      O2_LCACC = 5'h0B,
      O2_INCIX = 5'h0C,
      O2_TDAT = 5'h0D,
      O2_TJMP = 5'h0E,
      O2_JDUAL = 5'h0F,
      O2_LDBAS = 5'h10,
      O2_MODE = 5'h11,
      O2_DUAL = 5'h12,
      O2_BLK = 5'h13
   } sigp_op2_t;

endpackage

// File: design/sigp_imem.sv
`timescale 1ns/1ns
module sigp_imem #(
   parameter int WORDS = 256,
   parameter int AW = 8,
   parameter int DW = 17
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [0:WORDS-1];

   if (WORDS > (1 << AW)) begin : g_chk
      $error("sigp_imem: depth exceeds address range");
   end

   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read keeps the fetch path short
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// File: design/sigp_dmem.sv
`timescale 1ns/1ns
module sigp_dmem #(
   parameter int BASES = 32,
   parameter int BW = 5,
   parameter int DISPS = 8,
   parameter int DW_D = 3,
   parameter int RAMS = 4,
   parameter int DW = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [BW-1:0] u_base,
   input wire logic [BW-1:0] v_base,
   output logic [DISPS*DW-1:0] u_row,
   output logic [DISPS*DW-1:0] v_row,
   input wire logic wr_en,
   input wire logic wr_force,
   input wire logic [BW-1:0] wr_base,
   input wire logic [DW_D-1:0] wr_disp,
   input wire logic [DW-1:0] wr_data
);
   if (RAMS > DISPS || DISPS > (1 << DW_D)) begin : g_chk
      $error("sigp_dmem: bad displacement sizing");
   end

   // -------------------------------------------
   // One bank per displacement, all read at once
   // -------------------------------------------
   for (genvar d = 0; d < DISPS; d++) begin : g_bank
      logic [DW-1:0] bank [0:BASES-1];
      // Upper displacements are constants: only the load port reaches them
      logic wr_ok;
      assign wr_ok = wr_en && (wr_disp == DW_D'(d)) && (d < RAMS || wr_force); // (RULE4)
      always_ff @(posedge sys_clk) begin
         if (wr_ok) begin
            bank[wr_base] <= wr_data;
         end
      end
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            u_row[d*DW +: DW] <= '0;
            v_row[d*DW +: DW] <= '0;
         end else begin
            u_row[d*DW +: DW] <= bank[u_base]; // (RULE3)
            v_row[d*DW +: DW] <= bank[v_base]; // (RULE5)
         end
      end
   end
endmodule

// File: tb/sigp_monitor.sv
`timescale 1ns/1ns
module sigp_monitor
   import sigp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic prog_we,
   input wire logic [sigp_pkg::IADDR_W-1:0] prog_addr,
   input wire logic [sigp_pkg::INSTR_W-1:0] prog_data,
   input wire logic const_we,
   input wire logic [7:0] const_addr,
   input wire logic [sigp_pkg::DATA_W-1:0] const_data,
   input wire logic in_we,
   input wire logic [sigp_pkg::DATA_W-1:0] in_data,
   input wire logic [sigp_pkg::DATA_W-1:0] out_data,
   input wire logic out_valid
);
   default clocking mon_cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Cycles since the last output
   // ----------------------------------------
   // Saturates so a long idle spell never wraps into a false short gap
   logic [4:0] gap_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gap_r <= 5'h1F;
      end else begin
         gap_r <= out_valid ? 5'h00 : (!run || gap_r == 5'h1F) ? 5'h1F : gap_r + 5'h01;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   reset_zero_a: assert property (disable iff (1'b0) rst |-> out_data == 16'h0000 && !out_valid)
      else $error("output not clear during reset");
   reset_exit_a: assert property ($fell(rst) |-> out_data == 16'h0000 && !out_valid)
      else $error("output not clear after reset");
   start_quiet_a: assert property ($rose(run) |-> !out_valid [*3])
      else $error("output too soon after start");
   idle_quiet_a: assert property (!run [*2] |-> !out_valid)
      else $error("output while stopped");
   valid_pulse_a: assert property (out_valid |=> !out_valid)
      else $error("output strobe longer than one cycle");
   out_hold_a: assert property ($changed(out_data) |-> out_valid)
      else $error("output word changed without strobe");
   instr_gap_a: assert property (out_valid |-> gap_r >= 5'h0E)
      else $error("outputs closer than one instruction");
   run_cause_a: assert property (out_valid |-> $past(run))
      else $error("output without execution");
endmodule

bind sigp_signal_coprocessor sigp_monitor u_mon (
   .sys_clk(sys_clk),
   .rst(rst),
   .run(run),
   .prog_we(prog_we),
   .prog_addr(prog_addr),
   .prog_data(prog_data),
   .const_we(const_we),
   .const_addr(const_addr),
   .const_data(const_data),
   .in_we(in_we),
   .in_data(in_data),
   .out_data(out_data),
   .out_valid(out_valid)
);

// File: tb/sigp_host_model.sv
`timescale 1ns/1ns
module sigp_host_model
   import sigp_pkg::*;
(
   input wire logic sys_clk,
   output logic in_we,
   output logic [sigp_pkg::DATA_W-1:0] in_data,
   input wire logic [sigp_pkg::DATA_W-1:0] out_data,
   input wire logic out_valid
);
   logic [15:0] last_out;
   int n_out;
   initial begin
      in_we = 1'b0;
      in_data = 16'h0000;
      last_out = 16'h0000;
      n_out = 0;
   end
   // The strobe stands one cycle, so the word is taken at that edge
   always @(posedge sys_clk) begin
      if (out_valid === 1'b1) begin
         last_out <= out_data;
         n_out <= n_out + 1;
      end
   end
   // Released data shows the inverse so a stale value cannot pass
   task automatic put_input(input logic [15:0] v);
      @(negedge sys_clk);
      in_we = 1'b1;
      in_data = v;
      @(negedge sys_clk);
      in_we = 1'b0;
      in_data = ~v;
   endtask
endmodule

// File: tb/signal_processor_datapath_bench.sv
`timescale 1ns/1ns
module signal_processor_datapath_bench;
   import sigp_pkg::*;
   typedef struct packed {
      sigp_op1_t op1;
      sigp_op2_t op2;
      logic [15:0] a;
      logic [15:0] b;
   } sigp_row_t;
   localparam logic [15:0] VC = 16'h0100;
   logic sys_clk, rst, run, prog_we, const_we, in_we, out_valid;
   logic [7:0] prog_addr, const_addr;
   logic [16:0] prog_data;
   logic [15:0] const_data, in_data, out_data;
   logic [16:0] prog [8];
   logic [15:0] cv [8] = '{16'h1234, 16'h1111, 16'h2222, 16'h3333, 16'h0000, 16'h0000, VC, 16'h7777};
   logic [15:0] lcv [4] = '{16'h0028, 16'h0003, 16'h2800, 16'hF800};
   int n_mismatch = 0;
   int compares = 0;
   int nl;
   sigp_row_t rows [20] = '{
      '{O1_LDP, O2_CALL, 16'h4000, 16'h2000}, '{O1_APA, O2_CALL, 16'h4000, 16'h2000},
      '{O1_APU, O2_CALL, 16'h4000, 16'h2000}, '{O1_SPA, O2_CALL, 16'h4000, 16'h2000},
      '{O1_SPU, O2_CALL, 16'h4000, 16'h2000}, '{O1_LDP, O2_CALL, 16'h400F, 16'h200F},
      '{O1_LDP, O2_CALL, 16'h8000, 16'h8000}, '{O1_LDP, O2_CALL, 16'hC000, 16'h4000},
      '{O1_AUV, O2_CALL, 16'h1234, 16'h5678}, '{O1_LDV, O2_CALL, 16'h1234, 16'h5678},
      '{O1_LDU, O2_CALL, 16'h1234, 16'h5678}, '{O1_SHR, O2_CALL, 16'h0000, 16'h8002},
      '{O1_CLR, O2_CALL, 16'h1234, 16'h5678}, '{O1_NOP, O2_CALL, 16'h1234, 16'h5678},
      '{O1_AUV, O2_JZ, 16'hFF00, 16'h5678}, '{O1_AUV, O2_JZ, 16'h0001, 16'h5678},
      '{O1_AUV, O2_JN, 16'h8000, 16'h5678}, '{O1_AUV, O2_JN, 16'h0001, 16'h5678},
      '{O1_AUV, O2_JO, 16'h7FFF, 16'h5678}, '{O1_AUV, O2_JO, 16'h0001, 16'h5678}};

   sigp_signal_coprocessor u_dut (.sys_clk(sys_clk), .rst(rst), .run(run), .prog_we(prog_we),
      .prog_addr(prog_addr), .prog_data(prog_data), .const_we(const_we), .const_addr(const_addr),
      .const_data(const_data), .in_we(in_we), .in_data(in_data), .out_data(out_data),
      .out_valid(out_valid));
   sigp_host_model u_host (.sys_clk(sys_clk), .in_we(in_we), .in_data(in_data), .out_data(out_data),
      .out_valid(out_valid));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   function automatic logic [16:0] w(sigp_op2_t o2, sigp_op1_t o1, logic [7:0] opr);
      return {o2, o1, opr};
   endfunction

   // Top 12 bits of each fraction, rounded, 16 bits kept
   function automatic logic [15:0] prod(logic [15:0] a, logic [15:0] b);
      logic signed [23:0] p;
      logic [23:0] r;
      p = $signed(a[15:4]) * $signed(b[15:4]);
      r = p + MUL_RND;
      return (a[15:4] == 12'h800 && b[15:4] == 12'h800) ? MUL_SAT : r[22:7];
   endfunction

   // Accumulator holds b, U is a, V is VC, product is a times b
   function automatic logic [15:0] expect_row(sigp_row_t r);
      logic [15:0] p, v;
      logic tk;
      p = prod(r.a, r.b);
      case (r.op1)
         O1_LDP: v = p;
         O1_APA: v = r.b + p;
         O1_APU: v = r.a + p;
         O1_SPA: v = r.b - p;
         O1_SPU: v = r.a - p;
         O1_AUV: v = r.a + VC;
         O1_LDV: v = VC;
         O1_LDU: v = r.a;
         O1_SHR: v = {r.b[15], r.b[15:1]};
         O1_CLR: v = 16'h0000;
         default: v = r.b;
      endcase
      case (r.op2)
         O2_JZ: tk = v == 16'h0000;
         O2_JN: tk = v[15];
         O2_JO: tk = r.a[15] == VC[15] && v[15] != r.a[15];
         default: tk = 1'b1;
      endcase
      return tk ? v : r.b;
   endfunction

   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic clear_prog();
      for (int i = 0; i < 8; i++) prog[i] = w(O2_CALL, O1_NOP, 8'(i));
   endtask

   // Loads program, base 0 and base 1 (sign bits flipped) while stopped, runs until one output appears
   task automatic run_chk(input logic [15:0] exp);
      int n0;
      @(negedge sys_clk);
      run = 1'b0;
      for (int i = 0; i < 16; i++) begin
         @(negedge sys_clk);
         prog_we = 1'b1;
         prog_addr = 8'(i % 8);
         prog_data = prog[i % 8];
         const_we = 1'b1;
         const_addr = 8'(i);
         const_data = cv[i % 8] ^ (i < 8 ? 16'h0000 : 16'h8000);
      end
      @(negedge sys_clk);
      prog_we = 1'b0;
      const_we = 1'b0;
      run = 1'b1;
      n0 = u_host.n_out;
      for (int k = 0; k < 1500 && u_host.n_out == n0; k++) @(negedge sys_clk);
      check_word(16'(u_host.n_out - n0), 16'h0001);
      check_word(u_host.last_out, exp);
      run = 1'b0;
      clear_prog();
   endtask

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #(20 * 40000);
      n_mismatch++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      run = 1'b0;
      prog_we = 1'b0;
      prog_addr = 8'h00;
      prog_data = 17'h00000;
      const_we = 1'b0;
      const_addr = 8'h00;
      const_data = 16'h0000;
      clear_prog();
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      check_word(out_data, 16'h0000);
      foreach (rows[r]) begin
         cv[4] = rows[r].a;
         cv[5] = rows[r].b;
         prog[0] = w(O2_NOP, O1_LDV, 8'hA5);
         prog[1] = w(O2_NOP, rows[r].op1, 8'hA6);
         prog[2] = w(rows[r].op2, O1_NOP, 8'h04);
         prog[3] = w(O2_NOP, O1_LDV, 8'hA5);
         prog[4] = w(O2_NOP, O1_OUT, 8'h00);
         run_chk(expect_row(rows[r]));
      end
      // Write-back must update writable displacement 1 and leave constant displacement 5 untouched
      for (int v = 1; v < 6; v += 4) begin
         prog[0] = w(O2_TACV, O1_LDU, {5'h10, 3'(v)});
         prog[1] = w(O2_NOP, O1_LDV, {5'h10, 3'(v)});
         prog[2] = w(O2_NOP, O1_OUT, 8'h00);
         run_chk(v == 1 ? cv[0] : cv[5]);
      end
      cv[4] = 16'h2468;
      prog[0] = w(O2_NOP, O1_NOP, 8'h84);
      prog[1] = w(O2_DELAYED_WRITEBACK_OP, O1_NOP, 8'h81);
      prog[2] = w(O2_NOP, O1_LDV, 8'h81);
      prog[3] = w(O2_NOP, O1_OUT, 8'h00);
      run_chk(cv[4]);
      prog[0] = w(O2_CALL, O1_NOP, 8'h03);
      prog[1] = w(O2_NOP, O1_OUT, 8'h00);
      prog[3] = w(O2_NOP, O1_LDV, 8'hA5);
      prog[4] = w(O2_RET, O1_NOP, 8'h00);
      run_chk(cv[5]);
      cv[4] = 16'h4000;
      cv[5] = VC;
      foreach (lcv[i]) begin
         prog[0] = i < 2 ? w(O2_LCIN, O1_NOP, 8'h00) : w(O2_NOP, O1_LDU, 8'hB5);
         prog[1] = i < 2 ? w(O2_NOP, O1_NOP, 8'h00) : w(O2_LCACC, O1_NOP, 8'h00);
         prog[2] = w(O2_NOP, O1_CLR, 8'hA5);
         prog[3] = w(O2_NOP, O1_APA, 8'hA5);
         prog[4] = w(O2_JLC, O1_NOP, 8'h03);
         prog[5] = w(O2_NOP, O1_OUT, 8'h00);
         cv[6] = lcv[i];
         u_host.put_input(lcv[i]);
         nl = i < 2 ? (lcv[i] > 16'h0020 ? 32 : int'(lcv[i])) : int'(lcv[i][15:11]);
         run_chk(16'((nl + 1) * 128));
      end
      // Index, dual tracking, control mode and scratchpad paths
      prog[0] = w(O2_INCIX, O1_NOP, 8'h00);
      prog[1] = w(O2_TDAT, O1_NOP, 8'h85);
      prog[2] = w(O2_NOP, O1_OUT, 8'h00);
      run_chk(cv[5] ^ 16'h8000);
      prog[0] = w(O2_LDBAS, O1_NOP, 8'h01);
      prog[1] = w(O2_DUAL, O1_AUV, 8'h05);
      prog[2] = w(O2_NOP, O1_OUT, 8'h00);
      run_chk((cv[0] ^ 16'h8000) + cv[5]);
      prog[0] = w(O2_MODE, O1_LDU, 8'hA5);
      prog[1] = w(O2_NOP, O1_LDP, 8'h00);
      prog[2] = w(O2_NOP, O1_OUT, 8'h00);
      run_chk(prod(cv[4], cv[5]));
      // The scratch write must land in scratchpad word 0 and read back on the V port
      prog[0] = w(O2_TACV, O1_LDU, 8'hE0);
      prog[1] = w(O2_NOP, O1_LDV, 8'hC0);
      prog[2] = w(O2_NOP, O1_OUT, 8'h00);
      run_chk(cv[4]);
      // Reset in mid-run clears the output register at once
      run = 1'b1;
      repeat (5) @(negedge sys_clk);
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      check_word(out_data, 16'h0000);
      check_word({15'h0000, out_valid}, 16'h0000);
      rst = 1'b0;
      run = 1'b0;
      print_verdict();
   end
endmodule
